// >>> lan_dma_status_summary_tb.sv
`timescale 1ns/1ps
`include "ldss_defs.svh"
module lan_dma_status_summary_tb;
    import ldss_pkg::*;
    logic            ref_clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic [7:0]      awaddr = 8'h00, araddr = 8'h00;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0]     wdata = 32'h0000_0000, rdata;
    logic [3:0]      wstrb = 4'h0;
    logic            awready, wready, bvalid, arready, rvalid, irq, bus_master_en, soft_rst_out;
    logic [1:0]      bresp, rresp;
    logic [11:0]     event_lo = 12'h000, event_lo_clear;
    logic [1:0]      aux_summary = 2'h0;
    ldss_dma_state_t dma_state = '0;
    ldss_bus_err_t   bus_err = '0;
    int              n_errors = 0;
    int              tests_run = 0;
    logic [31:0]     d;
    logic [1:0]      r;

    always #2.5 ref_clk = ~ref_clk;

    ldss_status #(.ADDR_W(8), .SWR_CYCLES(8)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_lo(event_lo), .aux_summary(aux_summary), .dma_state(dma_state), .bus_err(bus_err),
        .event_lo_clear(event_lo_clear), .bus_master_en(bus_master_en),
        .soft_rst_out(soft_rst_out), .irq(irq)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // address and data are offered together, each dropped at its own handshake edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        resp = 2'h3;
        while (1'b1)
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        v = 32'hxxxx_xxxx;
        resp = 2'h3;
        while (1'b1)
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    task automatic pulse_event(input logic [11:0] bits);
        @(posedge ref_clk);
        event_lo <= bits;
        @(posedge ref_clk);
        event_lo <= 12'h000;
    endtask : pulse_event

    task automatic pulse_bus_err(input logic [2:0] k);
        @(posedge ref_clk);
        bus_err <= '{valid: 1'b1, kind: k};
        @(posedge ref_clk);
        bus_err <= '0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse_bus_err

    task automatic t_reset_values;
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("status reset", d, `LDSS_STATUS_RST);
        axi_rd(`LDSS_ADDR_IRQ_MASK, d, r);
        chk("mask reset", d, 32'h0000_0000);
        chk("master enable reset", {31'h0, bus_master_en}, 32'h0000_0001);
    endtask : t_reset_values

    task automatic t_summaries;
        pulse_event(12'h004);
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("normal latched", d, 32'h0001_0000);
        axi_wr(`LDSS_ADDR_STATUS, 32'hfffe_0a5a, r);
        chk("low clear pulse", {20'h0, event_lo_clear}, 32'h0000_0a5a);
        @(posedge ref_clk);
        chk("low clear ends", {20'h0, event_lo_clear}, 32'h0000_0000);
        axi_wr(`LDSS_ADDR_STATUS, 32'h0000_0000, r);
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("ignored writes", d, 32'h0001_0000);
        axi_wr(`LDSS_ADDR_STATUS, 32'h0001_0000, r);
        chk("write resp", {30'h0, r}, {30'h0, `LDSS_RESP_OKAY});
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("normal cleared", d, 32'h0000_0000);
        pulse_event(12'h800);
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("abnormal latched", d, 32'h0000_8000);
        axi_wr(`LDSS_ADDR_STATUS, 32'h0000_8000, r);
        aux_summary <= 2'h3;
        @(posedge ref_clk);
        aux_summary <= 2'h0;
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("aux summaries", d, 32'h0001_8000);
        axi_wr(`LDSS_ADDR_STATUS, 32'h0001_8000, r);
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("aux cleared", d, 32'h0000_0000);
    endtask : t_summaries

    task automatic t_bus_errors;
        logic [2:0] kinds [3] = '{`LDSS_KIND_PARITY, `LDSS_KIND_MASTER, `LDSS_KIND_TARGET};
        foreach (kinds[i])
        begin
            pulse_bus_err(kinds[i]);
            chk("master disabled", {31'h0, bus_master_en}, 32'h0000_0000);
            axi_rd(`LDSS_ADDR_STATUS, d, r);
            chk("fatal and kind", d, {6'h00, kinds[i], 23'h00_a000});
            axi_wr(`LDSS_ADDR_STATUS, 32'h0000_2000, r);
            axi_wr(`LDSS_ADDR_STATUS, 32'h0000_8000, r);
            axi_rd(`LDSS_ADDR_STATUS, d, r);
            chk("fatal cleared", d, {6'h00, kinds[i], 23'h00_0000});
            chk("master enabled", {31'h0, bus_master_en}, 32'h0000_0001);
        end
        axi_wr(`LDSS_ADDR_IRQ_ST, 32'h0000_0007, r);
    endtask : t_bus_errors

    task automatic t_dma_and_irq;
        axi_wr(`LDSS_ADDR_IRQ_MASK, 32'h0000_0007, r);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            dma_state <= '{tx_dma_state: 3'(i), rx_dma_state: 3'(7 - i)};
            axi_rd(`LDSS_ADDR_STATUS, d, r);
            chk("dma fields", {26'h0, d[22:17]}, {26'h0, 3'(i), 3'(7 - i)});
        end
        @(posedge ref_clk);
        dma_state <= '{tx_dma_state: `LDSS_TX_SUSPEND, rx_dma_state: `LDSS_RX_SUSPEND};
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("dma suspended", {26'h0, d[22:17]}, {26'h0, `LDSS_TX_SUSPEND, `LDSS_RX_SUSPEND});
        chk("no irq from states", {31'h0, irq}, 32'h0000_0000);
        pulse_event(12'h001);
        repeat (3) @(posedge ref_clk);
        chk("irq raised", {31'h0, irq}, 32'h0000_0001);
        axi_wr(`LDSS_ADDR_IRQ_MASK, 32'h0000_0000, r);
        repeat (2) @(posedge ref_clk);
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        axi_rd(`LDSS_ADDR_IRQ_ST, d, r);
        chk("irq status", d, 32'h0000_0001);
        axi_wr(`LDSS_ADDR_IRQ_MASK, 32'h0000_0007, r);
        axi_wr(`LDSS_ADDR_IRQ_ST, 32'h0000_0001, r);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    endtask : t_dma_and_irq

    task automatic t_unmapped;
        axi_wr(8'h40, 32'hffff_ffff, r);
        chk("unmapped write", {30'h0, r}, {30'h0, `LDSS_RESP_SLVERR});
        axi_rd(8'h40, d, r);
        chk("unmapped data", d, 32'h0000_0000);
        chk("unmapped read", {30'h0, r}, {30'h0, `LDSS_RESP_SLVERR});
    endtask : t_unmapped

    // a parity fault is left standing so that the soft reset is what recovers it
    task automatic t_soft_reset;
        dma_state <= '0;
        pulse_bus_err(`LDSS_KIND_PARITY);
        axi_wr(`LDSS_ADDR_CTRL, 32'h0000_0001, r);
        chk("soft reset running", {31'h0, soft_rst_out}, 32'h0000_0001);
        for (int n = 0; n < 40; n++)
        begin
            axi_rd(`LDSS_ADDR_CTRL, d, r);
            if (d[0] === 1'b0) break;
        end
        chk("soft reset self clear", d & 32'h0000_0001, 32'h0000_0000);
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("status after soft reset", d, 32'h0000_0000);
        chk("master after soft reset", {31'h0, bus_master_en}, 32'h0000_0001);
        axi_rd(`LDSS_ADDR_IRQ_MASK, d, r);
        chk("mask kept", d, 32'h0000_0007);
    endtask : t_soft_reset

    // a mid-run hardware reset clears the mask as well, unlike the soft reset
    task automatic t_sys_reset;
        pulse_bus_err(`LDSS_KIND_TARGET);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        axi_rd(`LDSS_ADDR_STATUS, d, r);
        chk("status after reset", d, `LDSS_STATUS_RST);
        chk("master after reset", {31'h0, bus_master_en}, 32'h0000_0001);
        axi_rd(`LDSS_ADDR_IRQ_MASK, d, r);
        chk("mask after reset", d, 32'h0000_0000);
    endtask : t_sys_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    initial
    begin
        #100000;
        n_errors++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_summaries();
        t_bus_errors();
        t_dma_and_irq();
        t_unmapped();
        t_soft_reset();
        t_sys_reset();
        final_report();
    end
endmodule : lan_dma_status_summary_tb

// >>> ldss_defs.svh
`ifndef LDSS_DEFS_SVH
`define LDSS_DEFS_SVH

// byte addresses
`define LDSS_ADDR_CTRL       8'h00
`define LDSS_ADDR_STATUS     8'h28
`define LDSS_ADDR_IRQ_ST     8'h80
`define LDSS_ADDR_IRQ_MASK   8'h84

// field positions in the status word, and of the soft reset bit in the control word
`define LDSS_POS_KIND        23
`define LDSS_POS_TX          20
`define LDSS_POS_RX          17
`define LDSS_POS_NORM        16
`define LDSS_POS_ABN         15
`define LDSS_POS_FATAL       13
`define LDSS_POS_SWR         0

// event bits that feed each summary
`define LDSS_NORM_SRC        12'h045
`define LDSS_ABN_SRC         12'hbaa

// bus error kinds
`define LDSS_KIND_PARITY     3'h0
`define LDSS_KIND_MASTER     3'h1
`define LDSS_KIND_TARGET     3'h2

// dma state codes
`define LDSS_TX_STOP         3'h0
`define LDSS_TX_SUSPEND      3'h6
`define LDSS_RX_STOP         3'h0
`define LDSS_RX_SUSPEND      3'h4

// interrupt status bits
`define LDSS_IRQ_NORM        0
`define LDSS_IRQ_ABN         1
`define LDSS_IRQ_FATAL       2

// reset values and responses
`define LDSS_STATUS_RST      32'h0000_0000
`define LDSS_RESP_OKAY       2'h0
`define LDSS_RESP_SLVERR     2'h2

// soft reset duration in cycles
`define LDSS_SWR_CYCLES      16

`endif

// >>> ldss_pkg.sv
package ldss_pkg;

    typedef struct packed {
        logic [2:0] bus_error_kind;
        logic [2:0] tx_dma_state;
        logic [2:0] rx_dma_state;
        logic       normal_irq_summary;
        logic       abnormal_irq_summary;
        logic       fatal_bus_fault;
    } ldss_upper_t;

    typedef struct packed {
        logic [2:0] tx_dma_state;
        logic [2:0] rx_dma_state;
    } ldss_dma_state_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] kind;
    } ldss_bus_err_t;

    typedef enum logic {
        LDSS_SWR_IDLE,
        LDSS_SWR_BUSY
    } ldss_swr_state_t;

endpackage : ldss_pkg

// >>> ldss_status.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ldss_defs.svh"
module ldss_status #(
    parameter int unsigned ADDR_W     = 8,
    parameter int unsigned SWR_CYCLES = `LDSS_SWR_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output wire logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output wire logic                   s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output wire logic                   s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [11:0]            event_lo,
    input  wire logic [1:0]             aux_summary,
    input  wire ldss_pkg::ldss_dma_state_t dma_state,
    input  wire ldss_pkg::ldss_bus_err_t   bus_err,
    output logic [11:0]                 event_lo_clear,
    output wire logic                   bus_master_en,
    output wire logic                   soft_rst_out,
    output wire logic                   irq
);
    import ldss_pkg::*;

    localparam int SWR_BOUND = SWR_CYCLES + 1;

    logic                  aw_q;
    logic [ADDR_W-1:0]     awaddr_q;
    logic                  w_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  rd_status_q;
    ldss_upper_t           up_q;
    ldss_upper_t           up_d;
    logic [2:0]            irq_st_q;
    logic [2:0]            irq_mask_q;
    ldss_swr_state_t       swr_state_q;
    logic [15:0]           swr_cnt_q;
    logic [31:0]           wmask;

    wire logic             swr_busy   = (swr_state_q == LDSS_SWR_BUSY);
    // soft reset clears live status but leaves the mask, which is configuration
    wire logic             int_rst    = sys_rst || swr_busy;
    wire logic             do_wr      = aw_q && w_q;
    wire logic [31:0]      clr        = wdata_q & wmask;
    wire logic [7:0]       waddr      = 8'({awaddr_q[ADDR_W-1:2], 2'b00});
    wire logic [7:0]       raddr      = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    wire logic             wr_ctrl    = do_wr && (waddr == `LDSS_ADDR_CTRL);
    wire logic             wr_status  = do_wr && (waddr == `LDSS_ADDR_STATUS);
    wire logic             wr_irq_st  = do_wr && (waddr == `LDSS_ADDR_IRQ_ST);
    wire logic             wr_mask    = do_wr && (waddr == `LDSS_ADDR_IRQ_MASK);
    wire logic             wr_hit     = wr_ctrl || wr_status || wr_irq_st || wr_mask;
    wire logic             rd_take    = s_axi_arvalid && s_axi_arready;
    wire logic             rd_ctrl    = (raddr == `LDSS_ADDR_CTRL);
    wire logic             rd_status  = (raddr == `LDSS_ADDR_STATUS);
    wire logic             rd_irq_st  = (raddr == `LDSS_ADDR_IRQ_ST);
    wire logic             rd_mask    = (raddr == `LDSS_ADDR_IRQ_MASK);
    wire logic             rd_hit     = rd_ctrl || rd_status || rd_irq_st || rd_mask;
    wire logic             swr_start  = wr_ctrl && clr[`LDSS_POS_SWR] && !swr_busy;

    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            assign wmask[lane*8 +: 8] = {8{wstrb_q[lane]}};
        end
    endgenerate

    // bits 16, 15 and 13 are cleared by software here; the kind field is never written by software
    wire logic norm_set  = (|(event_lo & `LDSS_NORM_SRC)) || aux_summary[1];
    wire logic abn_set   = (|(event_lo & `LDSS_ABN_SRC)) || up_q.fatal_bus_fault
                           || aux_summary[0];
    wire logic norm_clr  = wr_status && clr[`LDSS_POS_NORM];
    wire logic abn_clr   = wr_status && clr[`LDSS_POS_ABN];
    wire logic fatal_clr = wr_status && clr[`LDSS_POS_FATAL];

    always_comb
    begin
        up_d                      = up_q;
        up_d.tx_dma_state         = dma_state.tx_dma_state;
        up_d.rx_dma_state         = dma_state.rx_dma_state;
        // set wins over a simultaneous write-one clear
        up_d.normal_irq_summary   = norm_set || (up_q.normal_irq_summary && !norm_clr);
        up_d.abnormal_irq_summary = abn_set || (up_q.abnormal_irq_summary && !abn_clr);
        up_d.fatal_bus_fault      = bus_err.valid || (up_q.fatal_bus_fault && !fatal_clr);
        if (bus_err.valid)
        begin
            up_d.bus_error_kind   = bus_err.kind;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (int_rst)
            up_q <= ldss_upper_t'(0);
        else
            up_q <= up_d;
    end

    // fault is sticky, so mastering stays off until software clears or resets
    assign bus_master_en = !up_q.fatal_bus_fault;

    // kind field has no event of its own: only summary and fatal edges interrupt
    wire logic [2:0] irq_ev = {bus_err.valid && !up_q.fatal_bus_fault,
                               abn_set && !up_q.abnormal_irq_summary,
                               norm_set && !up_q.normal_irq_summary};
    wire logic [2:0] irq_clr = wr_irq_st ? clr[2:0] : 3'h0;

    always_ff @(posedge ref_clk)
    begin
        if (int_rst)
            irq_st_q <= 3'h0;
        else
            irq_st_q <= irq_ev | (irq_st_q & ~irq_clr);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_mask_q <= 3'h0;
        else if (wr_mask && wstrb_q[0])
            irq_mask_q <= wdata_q[2:0];
    end

    assign irq = |(irq_st_q & irq_mask_q);

    // host can use this path to recover from a parity fault; a write-one to bit 13 also clears it
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            swr_state_q <= LDSS_SWR_IDLE;
            swr_cnt_q   <= 16'h0;
        end
        else
        begin
            case (swr_state_q)
                LDSS_SWR_IDLE:
                begin
                    swr_cnt_q <= 16'h0;
                    if (swr_start)
                        swr_state_q <= LDSS_SWR_BUSY;
                end
                LDSS_SWR_BUSY:
                begin
                    swr_cnt_q <= swr_cnt_q + 16'h1;
                    if (swr_cnt_q == 16'(SWR_CYCLES - 1))
                        swr_state_q <= LDSS_SWR_IDLE;
                end
                default:
                    swr_state_q <= LDSS_SWR_IDLE;
            endcase
        end
    end

    assign soft_rst_out = swr_busy;

    // write address and data are taken independently; the response follows both
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            aw_q         <= 1'b0;
            awaddr_q     <= '0;
            w_q          <= 1'b0;
            wdata_q      <= 32'h0;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LDSS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `LDSS_RESP_OKAY : `LDSS_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    wire logic [31:0] status_word = {6'h0, up_q.bus_error_kind, up_q.tx_dma_state, up_q.rx_dma_state,
                                     up_q.normal_irq_summary, up_q.abnormal_irq_summary, 1'b0,
                                     up_q.fatal_bus_fault, 1'b0, event_lo};
    wire logic [31:0] rd_word = rd_status ? status_word :
                                rd_ctrl   ? {31'h0, swr_busy} :
                                rd_irq_st ? {29'h0, irq_st_q} :
                                rd_mask   ? {29'h0, irq_mask_q} : 32'h0;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `LDSS_RESP_OKAY;
            rd_status_q  <= 1'b0;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `LDSS_RESP_OKAY : `LDSS_RESP_SLVERR;
            rd_status_q  <= rd_status;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // low event bits live outside; pass their write-one clears on as a pulse
    always_ff @(posedge ref_clk)
    begin
        if (int_rst)
            event_lo_clear <= 12'h0;
        else
            event_lo_clear <= wr_status ? clr[11:0] : 12'h0;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_fault_records: assert property (bus_err.valid && !swr_busy |=> up_q.fatal_bus_fault
        && up_q.bus_error_kind == $past(bus_err.kind))
        else $error("bus error not recorded");
    a_kind_stable: assert property (!bus_err.valid && !swr_busy |=> $stable(up_q.bus_error_kind))
        else $error("kind field changed without a bus error");
    a_kind_no_irq: assert property ($rose(irq_st_q[`LDSS_IRQ_FATAL]) |-> $past(bus_err.valid))
        else $error("fatal interrupt without bus error");
    a_fault_holds: assert property (up_q.fatal_bus_fault && !fatal_clr && !swr_busy
        |=> up_q.fatal_bus_fault)
        else $error("fatal fault dropped without clear");
    a_master_off: assert property (bus_err.valid && !swr_busy |=> !bus_master_en)
        else $error("mastering allowed after fatal fault");
    a_norm_sets: assert property ((|(event_lo & `LDSS_NORM_SRC)) && !swr_busy
        |=> up_q.normal_irq_summary)
        else $error("normal summary not set");
    a_abn_sets: assert property (up_q.fatal_bus_fault && !swr_busy ##1 !swr_busy
        |-> up_q.abnormal_irq_summary)
        else $error("abnormal summary not set by fatal fault");
    a_state_track: assert property (!swr_busy |=> up_q.tx_dma_state == $past(dma_state.tx_dma_state)
        && up_q.rx_dma_state == $past(dma_state.rx_dma_state))
        else $error("dma state field not tracking");
    a_swr_zero: assert property (swr_busy |=> up_q == ldss_upper_t'(0) && irq_st_q == 3'h0)
        else $error("status not cleared by reset");
    a_swr_ends: assert property ($rose(swr_busy) |-> ##[1:SWR_BOUND] !swr_busy)
        else $error("soft reset did not clear itself");
    a_rsvd_zero: assert property (s_axi_rvalid && rd_status_q |-> s_axi_rdata[31:26] == 6'h0
        && !s_axi_rdata[14] && !s_axi_rdata[12])
        else $error("reserved status bits read nonzero");
    a_norm_clears: assert property (up_q.normal_irq_summary && norm_clr && !norm_set && !swr_busy
        |=> !up_q.normal_irq_summary)
        else $error("normal summary not cleared by write-one");
    a_abn_clears: assert property (up_q.abnormal_irq_summary && abn_clr && !abn_set && !swr_busy
        |=> !up_q.abnormal_irq_summary)
        else $error("abnormal summary not cleared by write-one");
    a_low_clear: assert property (wr_status && !swr_busy |=> event_lo_clear == $past(clr[11:0]))
        else $error("low event clear pulse wrong");

    c_fault: cover property (bus_err.valid && bus_err.kind == `LDSS_KIND_TARGET ##1 !bus_master_en);
    c_clear: cover property (up_q.fatal_bus_fault ##1 fatal_clr ##1 bus_master_en);
    c_swr: cover property ($rose(swr_busy) ##[1:SWR_BOUND] $fell(swr_busy));
    c_irq: cover property ($rose(irq) && up_q.tx_dma_state == `LDSS_TX_SUSPEND);

endmodule : ldss_status
